// ---- rtl/mpr_eeprom_loader.sv ----
`timescale 1ns/1ns
// Two-wire master that reads the default bytes from address zero of the EEPROM.
module mpr_eeprom_loader (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic abort,
	input wire logic start,
	input wire logic sdaIn,
	output logic sclOut,
	output logic sdaLow,
	output logic busy,
	output logic done,
	output logic error,
	output logic byteValid,
	output logic [7:0] byteData,
	output logic [7:0] byteIndex
);
	typedef enum {LD_IDLE, LD_START, LD_SEND, LD_READ, LD_STOP, LD_DONE} mpr_ld_state_t;

	mpr_ld_state_t state_q, state_d;
	logic [7:0] tick_q, tick_d, shift_q, shift_d, idx_q, idx_d;
	logic [1:0] qtr_q, qtr_d, txSel_q, txSel_d;
	logic [3:0] bit_q, bit_d;
	logic scl_q, scl_d, sdaLow_q, sdaLow_d, err_q, err_d, done_q, done_d, valid_q, valid_d;
	logic tick, lastByte;

	function automatic logic [7:0] txByte(input logic [1:0] sel);
		case (sel)
			2'd0: txByte = mpr_pkg::EE_ADDR_WRITE;
			2'd1: txByte = mpr_pkg::EE_WORD_ADDR;
			default: txByte = mpr_pkg::EE_ADDR_READ;
		endcase
	endfunction

	assign tick = (tick_q == mpr_pkg::SCL_QUARTER_LAST);
	assign lastByte = (idx_q == 8'(mpr_pkg::LOAD_BYTES - 1));

	// Every phase change lands on a quarter tick, so SDA never moves while SCL is high
	// except for the start and stop conditions.
	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		idx_d = idx_q;
		qtr_d = qtr_q;
		txSel_d = txSel_q;
		bit_d = bit_q;
		scl_d = scl_q;
		sdaLow_d = sdaLow_q;
		err_d = err_q;
		done_d = done_q;
		valid_d = 1'b0;
		tick_d = tick ? 8'h00 : tick_q + 8'h01;
		if (tick) begin
			qtr_d = qtr_q + 2'd1;
		end
		case (state_q)
			LD_IDLE, LD_DONE: begin
				tick_d = 8'h00;
				qtr_d = 2'd0;
				scl_d = 1'b1;
				sdaLow_d = 1'b0;
				if (start) begin
					state_d = LD_START;
					txSel_d = 2'd0;
					idx_d = 8'h00;
					err_d = 1'b0;
					done_d = 1'b0;
				end
			end
			LD_START: begin
				if (tick) begin
					case (qtr_q)
						2'd0: sdaLow_d = 1'b0;
						2'd1: scl_d = 1'b1;
						2'd2: sdaLow_d = 1'b1;
						default: begin
							scl_d = 1'b0;
							state_d = LD_SEND;
							bit_d = 4'd0;
							shift_d = txByte(txSel_q);
						end
					endcase
				end
			end
			LD_SEND: begin
				if (tick) begin
					case (qtr_q)
						2'd0: sdaLow_d = (bit_q == 4'd8) ? 1'b0 : !shift_q[7];
						2'd1: scl_d = 1'b1;
						2'd2: err_d = err_q | ((bit_q == 4'd8) & sdaIn);
						default: begin
							scl_d = 1'b0;
							if (bit_q != 4'd8) begin
								shift_d = {shift_q[6:0], 1'b0};
								bit_d = bit_q + 4'd1;
							end else if (err_q) begin
								state_d = LD_STOP;
							end else if (txSel_q == 2'd0) begin
								txSel_d = 2'd1;
								bit_d = 4'd0;
								shift_d = txByte(2'd1);
							end else if (txSel_q == 2'd1) begin
								txSel_d = 2'd2;
								state_d = LD_START;
							end else begin
								state_d = LD_READ;
								bit_d = 4'd0;
							end
						end
					endcase
				end
			end
			LD_READ: begin
				if (tick) begin
					case (qtr_q)
						2'd0: sdaLow_d = (bit_q == 4'd8) && !lastByte;
						2'd1: scl_d = 1'b1;
						2'd2: begin
							if (bit_q != 4'd8) begin
								shift_d = {shift_q[6:0], sdaIn};
							end
						end
						default: begin
							scl_d = 1'b0;
							if (bit_q != 4'd8) begin
								bit_d = bit_q + 4'd1;
							end else begin
								valid_d = 1'b1;
								bit_d = 4'd0;
								if (lastByte) begin
									state_d = LD_STOP;
								end
							end
						end
					endcase
				end
			end
			LD_STOP: begin
				if (tick) begin
					case (qtr_q)
						2'd0: begin
							scl_d = 1'b0;
							sdaLow_d = 1'b1;
						end
						2'd1: scl_d = 1'b1;
						2'd2: sdaLow_d = 1'b0;
						default: begin
							state_d = LD_DONE;
							done_d = 1'b1;
						end
					endcase
				end
			end
			default: state_d = LD_IDLE;
		endcase
		// The index moves on only in the cycle after the byte strobe. The collector
		// then sees each byte together with its own number and not with the next one.
		if (valid_q && !lastByte) begin
			idx_d = idx_q + 8'h01;
		end
		// A bus reset in mid-read drops the transfer and releases both lines.
		if (abort) begin
			state_d = LD_IDLE;
			scl_d = 1'b1;
			sdaLow_d = 1'b0;
			done_d = 1'b0;
			tick_d = 8'h00;
		end
	end

	// Loader registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= LD_IDLE;
			tick_q <= 8'h00;
			shift_q <= 8'h00;
			idx_q <= 8'h00;
			qtr_q <= 2'd0;
			txSel_q <= 2'd0;
			bit_q <= 4'd0;
			scl_q <= 1'b1;
			sdaLow_q <= 1'b0;
			err_q <= 1'b0;
			done_q <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tick_q <= tick_d;
			shift_q <= shift_d;
			idx_q <= idx_d;
			qtr_q <= qtr_d;
			txSel_q <= txSel_d;
			bit_q <= bit_d;
			scl_q <= scl_d;
			sdaLow_q <= sdaLow_d;
			err_q <= err_d;
			done_q <= done_d;
			valid_q <= valid_d;
		end
	end

	assign sclOut = scl_q;
	assign sdaLow = sdaLow_q;
	assign busy = (state_q != LD_IDLE) && (state_q != LD_DONE);
	assign done = done_q;
	assign error = err_q;
	assign byteValid = valid_q;
	assign byteData = shift_q;
	assign byteIndex = idx_q;
endmodule

// ---- rtl/mpr_pkg.sv ----
package mpr_pkg;

	// Pin count and width of one routing field.
	localparam int PIN_COUNT = 7;
	localparam int FN_WIDTH = 4;
	localparam int GPO_COUNT = 5;

	// Function codes of a routing field; code zero leaves the pin undriven.
	localparam logic [3:0] FN_INPUT = 4'h0;
	localparam logic [3:0] FN_INTX = 4'h1;
	localparam logic [3:0] FN_GPO = 4'h2;
	localparam logic [3:0] FN_LED = 4'h3;
	localparam logic [3:0] FN_VIDEO = 4'h4;
	localparam logic [3:0] FN_PWM = 4'h5;
	localparam logic [3:0] FN_GPE = 4'h6;
	localparam logic [3:0] FN_IRQ = 4'h7;
	localparam logic [3:0] FN_RING = 4'h8;
	localparam logic [3:0] FN_SERIRQ = 4'h9;
	localparam logic [3:0] FN_CLKRUN = 4'hA;
	localparam logic [3:0] FN_LOCK = 4'hB;
	localparam logic [3:0] FN_DMAREQ = 4'hC;
	localparam logic [3:0] FN_DMAGNT = 4'hD;

	// One bit per function code that each pin may take, pin 0 first.
	localparam logic [15:0] FN_LEGAL [PIN_COUNT] = '{
		16'h00FF, 16'h00FF, 16'h11FD, 16'h0281, 16'h09FD, 16'h20FD, 16'h0481
	};

	// General input and output index carried by each pin; pins 3 and 6 carry none and hold 0.
	localparam int GPIO_MAP [PIN_COUNT] = '{0, 1, 2, 0, 3, 4, 0};

	// Pins taken over by the serial EEPROM interface.
	localparam int SDA_PIN = 1;
	localparam int SCL_PIN = 4;

	// Values after reset.
	localparam logic [27:0] ROUTE_RESET = 28'h000_0000;
	localparam logic [4:0] GPO_RESET = 5'h00;

	// Serial clock timing: a quarter of a bit is the unit of the loader.
	localparam int CLOCK_KHZ = 20000;
	localparam int SCL_HALF_NS = 5000;
	localparam int SCL_QUARTER_CYCLES = (SCL_HALF_NS / 2) * CLOCK_KHZ / 1000000;
	localparam logic [7:0] SCL_QUARTER_LAST = 8'(SCL_QUARTER_CYCLES - 1);

	// EEPROM read sequence.
	localparam logic [7:0] EE_ADDR_WRITE = 8'hA0;
	localparam logic [7:0] EE_WORD_ADDR = 8'h00;
	localparam logic [7:0] EE_ADDR_READ = 8'hA1;
	localparam int LOAD_BYTES = 4;

endpackage

// ---- rtl/mpr_router.sv ----
`timescale 1ns/1ns
module mpr_router (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [6:0] pinIn,
	output logic [6:0] pinOut,
	output logic [6:0] pinOe,
	input wire logic eepromStrap,
	input wire logic globalResetIn_n,
	input wire logic busResetIn_n,
	input wire logic registerHold,
	input wire logic [1:0] cardSpeakerIn,
	input wire logic routeWrite,
	input wire logic [27:0] routeWrData,
	input wire logic gpoWrite,
	input wire logic [4:0] gpoWrData,
	input wire logic intaReq,
	input wire logic intbReq,
	input wire logic ledActive,
	input wire logic videoSwitch,
	input wire logic audioPwm,
	input wire logic gpeEvent,
	input wire logic [6:0] parIrq,
	input wire logic ringIndicate,
	input wire logic powerEvent,
	input wire logic ringPmeSelect,
	input wire logic serirqOut,
	input wire logic serirqOe,
	input wire logic clkrunLow,
	input wire logic dmaReq,
	output logic [27:0] route,
	output logic [4:0] gpo,
	output logic [4:0] generalInput,
	output logic lockIn,
	output logic dmaGrant,
	output logic clkrunIn,
	output logic serirqIn,
	output logic ringPmeOut,
	output logic hostSpeakerOut,
	output logic eepromMode,
	output logic eepromDone,
	output logic eepromError,
	output logic [15:0] subsystemId,
	output logic [15:0] loadedDefaults
);
	logic [6:0] pinSync;
	logic [5:0] ctlSync;
	logic strapS, grstS_n, prstS_n, holdS;
	logic [1:0] spkS;
	logic regClear, prstRelease;
	logic ldScl, ldSdaLow, ldBusy, ldDone, ldErr, ldValid;
	logic [7:0] ldData, ldIndex;

	logic [27:0] route_q, route_d;
	logic [4:0] gpo_q, gpo_d;
	logic [31:0] loaded_q, loaded_d;
	logic eeMode_q, eeMode_d, prstPrev_q, ldStart_q, ldStart_d;
	logic [6:0] pinOut_q, pinOut_d, pinOe_q, pinOe_d;
	logic [4:0] gpi_q, gpi_d;
	logic lock_q, lock_d, gnt_q, gnt_d, clkrun_q, clkrun_d, serirq_q, serirq_d;
	logic ringPme_q, ringPme_d, spk_q, spk_d;

	// Routing field of one pin, forced back to the undriven code if the pin lacks it.
	function automatic logic [3:0] legalCode(input int pin, input logic [27:0] fields);
		logic [3:0] code;
		code = fields[pin*mpr_pkg::FN_WIDTH +: mpr_pkg::FN_WIDTH];
		legalCode = mpr_pkg::FN_LEGAL[pin][code] ? code : mpr_pkg::FN_INPUT;
	endfunction

	// Every pin-side level goes through two flops before anything reads it.
	mpr_sync #(.WIDTH(7)) u_pinSync (
		.clock(clock),
		.rst_n(rst_n),
		.din(pinIn),
		.dout(pinSync)
	);

	mpr_sync #(.WIDTH(6)) u_ctlSync (
		.clock(clock),
		.rst_n(rst_n),
		.din({eepromStrap, globalResetIn_n, busResetIn_n, registerHold, cardSpeakerIn}),
		.dout(ctlSync)
	);

	assign {strapS, grstS_n, prstS_n, holdS, spkS} = ctlSync;

	// The hold input shields the registers from both system resets.
	assign regClear = (!grstS_n || !prstS_n) && !holdS;
	assign prstRelease = prstS_n && !prstPrev_q;

	mpr_eeprom_loader u_loader (
		.clock(clock),
		.rst_n(rst_n),
		.abort(!prstS_n),
		.start(ldStart_q),
		.sdaIn(pinSync[mpr_pkg::SDA_PIN]),
		.sclOut(ldScl),
		.sdaLow(ldSdaLow),
		.busy(ldBusy),
		.done(ldDone),
		.error(ldErr),
		.byteValid(ldValid),
		.byteData(ldData),
		.byteIndex(ldIndex)
	);

	// Software registers, strap capture and EEPROM byte collection.
	always_comb begin
		route_d = route_q;
		gpo_d = gpo_q;
		loaded_d = loaded_q;
		eeMode_d = eeMode_q;
		ldStart_d = 1'b0;
		if (routeWrite) begin
			for (int p = 0; p < mpr_pkg::PIN_COUNT; p++) begin
				route_d[p*mpr_pkg::FN_WIDTH +: mpr_pkg::FN_WIDTH] = legalCode(p, routeWrData);
			end
		end
		if (gpoWrite) begin
			gpo_d = gpoWrData;
		end
		// The strap is only looked at on the edge where the bus reset lets go.
		if (prstRelease) begin
			eeMode_d = !strapS;
			ldStart_d = !strapS;
		end
		if (ldValid && ldIndex < 8'(mpr_pkg::LOAD_BYTES)) begin
			loaded_d[ldIndex[1:0]*8 +: 8] = ldData;
		end
		if (regClear) begin
			route_d = mpr_pkg::ROUTE_RESET;
			gpo_d = mpr_pkg::GPO_RESET;
		end
	end

	// Register group; the strap choice survives as long as the loader needs it.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			route_q <= mpr_pkg::ROUTE_RESET;
			gpo_q <= mpr_pkg::GPO_RESET;
			loaded_q <= 32'h0000_0000;
			eeMode_q <= 1'b0;
			ldStart_q <= 1'b0;
			prstPrev_q <= 1'b0;
		end else begin
			route_q <= route_d;
			gpo_q <= gpo_d;
			loaded_q <= loaded_d;
			eeMode_q <= eeMode_d;
			ldStart_q <= ldStart_d;
			prstPrev_q <= prstS_n;
		end
	end

	// Pin drivers. Open-drain functions enable the pad only to pull it low.
	always_comb begin
		logic [3:0] code;
		code = mpr_pkg::FN_INPUT;
		pinOut_d = 7'h00;
		pinOe_d = 7'h00;
		gpi_d = gpi_q;
		lock_d = 1'b1;
		gnt_d = 1'b1;
		clkrun_d = 1'b0;
		serirq_d = 1'b1;
		for (int p = 0; p < mpr_pkg::PIN_COUNT; p++) begin
			code = route_q[p*mpr_pkg::FN_WIDTH +: mpr_pkg::FN_WIDTH];
			case (code)
				mpr_pkg::FN_INPUT: begin
					if (mpr_pkg::FN_LEGAL[p][mpr_pkg::FN_GPO]) begin
						gpi_d[mpr_pkg::GPIO_MAP[p]] = pinSync[p];
					end
				end
				mpr_pkg::FN_INTX: begin
					pinOe_d[p] = (p == 0) ? intaReq : intbReq;
				end
				mpr_pkg::FN_GPO: begin
					pinOut_d[p] = gpo_q[mpr_pkg::GPIO_MAP[p]];
					pinOe_d[p] = 1'b1;
				end
				mpr_pkg::FN_LED, mpr_pkg::FN_VIDEO, mpr_pkg::FN_PWM, mpr_pkg::FN_GPE,
				mpr_pkg::FN_RING, mpr_pkg::FN_IRQ, mpr_pkg::FN_DMAREQ: begin
					pinOe_d[p] = 1'b1;
					case (code)
						mpr_pkg::FN_LED: pinOut_d[p] = ledActive;
						mpr_pkg::FN_VIDEO: pinOut_d[p] = videoSwitch;
						mpr_pkg::FN_PWM: pinOut_d[p] = audioPwm;
						mpr_pkg::FN_GPE: pinOut_d[p] = gpeEvent;
						mpr_pkg::FN_RING: pinOut_d[p] = ringIndicate;
						mpr_pkg::FN_DMAREQ: pinOut_d[p] = dmaReq;
						default: pinOut_d[p] = parIrq[p];
					endcase
				end
				mpr_pkg::FN_SERIRQ: begin
					pinOut_d[p] = serirqOut;
					pinOe_d[p] = serirqOe;
					serirq_d = pinSync[p];
				end
				mpr_pkg::FN_CLKRUN: begin
					pinOe_d[p] = clkrunLow;
					clkrun_d = pinSync[p];
				end
				mpr_pkg::FN_LOCK: lock_d = pinSync[p];
				mpr_pkg::FN_DMAGNT: gnt_d = pinSync[p];
				default: pinOe_d[p] = 1'b0;
			endcase
		end
		// The serial interface wins over any routing of its two pins.
		if (eeMode_q) begin
			pinOut_d[mpr_pkg::SDA_PIN] = 1'b0;
			pinOe_d[mpr_pkg::SDA_PIN] = ldBusy && ldSdaLow;
			pinOut_d[mpr_pkg::SCL_PIN] = ldScl;
			pinOe_d[mpr_pkg::SCL_PIN] = ldBusy;
		end
		ringPme_d = ringPmeSelect ? powerEvent : ringIndicate;
		spk_d = spkS[0] ^ spkS[1];
	end

	// Output flops; nothing reaches a port without passing one.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinOut_q <= 7'h00;
			pinOe_q <= 7'h00;
			gpi_q <= 5'h00;
			lock_q <= 1'b1;
			gnt_q <= 1'b1;
			clkrun_q <= 1'b0;
			serirq_q <= 1'b1;
			ringPme_q <= 1'b0;
			spk_q <= 1'b0;
		end else begin
			pinOut_q <= pinOut_d;
			pinOe_q <= pinOe_d;
			gpi_q <= gpi_d;
			lock_q <= lock_d;
			gnt_q <= gnt_d;
			clkrun_q <= clkrun_d;
			serirq_q <= serirq_d;
			ringPme_q <= ringPme_d;
			spk_q <= spk_d;
		end
	end

	assign pinOut = pinOut_q;
	assign pinOe = pinOe_q;
	assign route = route_q;
	assign gpo = gpo_q;
	assign generalInput = gpi_q;
	assign lockIn = lock_q;
	assign dmaGrant = gnt_q;
	assign clkrunIn = clkrun_q;
	assign serirqIn = serirq_q;
	assign ringPmeOut = ringPme_q;
	assign hostSpeakerOut = spk_q;
	assign eepromMode = eeMode_q;
	assign eepromDone = ldDone;
	assign eepromError = ldErr;
	assign subsystemId = loaded_q[15:0];
	assign loadedDefaults = loaded_q[31:16];
endmodule

// ---- rtl/mpr_sync.sv ----
`timescale 1ns/1ns
// Two-stage synchroniser for pins that come from outside the clock domain.
module mpr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	// The first stage feeds only the second one.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// ---- verif/mpr_eeprom_model.sv ----
`timescale 1ns/1ns
// Serial EEPROM stand-in: acknowledges its own address and returns four stored bytes.
module mpr_eeprom_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nackAddr,
	output logic sdaLow
);
	logic [7:0] mem [4] = '{8'h3C, 8'hA5, 8'h5A, 8'hC3};
	logic [7:0] sh = 8'h00;
	int bitCnt = 0;
	int byteNo = 0;
	logic first = 1'b0;
	logic rd = 1'b0;

	initial begin
		sdaLow = 1'b0;
	end

	// Start and stop both reset the bit count; a repeated start clears a stray clock.
	always @(negedge sda) begin
		if (scl) begin
			bitCnt = 0;
			first = 1'b1;
			sdaLow = 1'b0;
		end
	end

	always @(posedge sda) begin
		if (scl) begin
			rd = 1'b0;
			first = 1'b0;
			bitCnt = 0;
		end
	end

	// Bits are taken on the rising clock; a high level at the ninth bit ends a read.
	always @(posedge scl) begin
		if (bitCnt < 8) begin
			sh = {sh[6:0], sda};
		end
		bitCnt = bitCnt + 1;
		if (bitCnt == 9 && rd) begin
			if (sda) begin
				rd = 1'b0;
			end else begin
				byteNo = byteNo + 1;
			end
		end
	end

	// The line only changes while the clock is low, as the two-wire bus demands.
	always @(negedge scl) begin
		if (bitCnt == 8) begin
			if (first) begin
				rd = sh[0];
				byteNo = -1;
				first = 1'b0;
				sdaLow = !nackAddr && sh[7:1] == 7'h50;
			end else begin
				sdaLow = !rd;
			end
		end else if (bitCnt == 9) begin
			bitCnt = 0;
			sdaLow = rd && !mem[byteNo][7];
		end else if (rd && bitCnt > 0) begin
			sdaLow = !mem[byteNo][7 - bitCnt];
		end
	end
endmodule

// ---- verif/mpr_router_asserts.sv ----
`timescale 1ns/1ns
// Port-level checks of the router; a pin follows the route field it saw one cycle earlier.
module mpr_router_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [27:0] route,
	input wire logic [6:0] pinOut,
	input wire logic [6:0] pinOe,
	input wire logic [4:0] gpo,
	input wire logic [1:0] cardSpeakerIn,
	input wire logic hostSpeakerOut,
	input wire logic ringPmeSelect,
	input wire logic powerEvent,
	input wire logic ringIndicate,
	input wire logic ringPmeOut,
	input wire logic ledActive,
	input wire logic intaReq,
	input wire logic [6:0] parIrq,
	input wire logic clkrunLow,
	input wire logic registerHold,
	input wire logic routeWrite,
	input wire logic eepromMode
);
	logic [1:0] upCnt_q;
	logic [1:0] upCnt_d;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Edges since reset, so that synchroniser stages still holding reset values are not judged.
	always_comb begin
		upCnt_d = (upCnt_q == 2'h3) ? upCnt_q : upCnt_q + 2'h1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			upCnt_q <= 2'h0;
		end else begin
			upCnt_q <= upCnt_d;
		end
	end

	a_speaker_xor: assert property (upCnt_q == 2'h3 |-> hostSpeakerOut == ^$past(cardSpeakerIn, 3))
		else $error("speaker output is not the xor of the card inputs");
	a_ring_pme_sel: assert property (upCnt_q != 2'h0 |-> ringPmeOut ==
		($past(ringPmeSelect) ? $past(powerEvent) : $past(ringIndicate)))
		else $error("ring or power event output wrong");
	a_led_pin_zero: assert property (route[3:0] == mpr_pkg::FN_LED |=>
		pinOe[0] && pinOut[0] == $past(ledActive))
		else $error("pin 0 does not carry the activity led");
	a_inta_pin_zero: assert property (route[3:0] == mpr_pkg::FN_INTX |=>
		pinOe[0] == $past(intaReq) && !pinOut[0])
		else $error("pin 0 interrupt is not an open drain low");
	a_irq_pin_three: assert property (route[15:12] == mpr_pkg::FN_IRQ |=>
		pinOe[3] && pinOut[3] == $past(parIrq[3]))
		else $error("pin 3 does not carry its parallel irq");
	a_clkrun_pin_six: assert property (route[27:24] == mpr_pkg::FN_CLKRUN |=>
		pinOe[6] == $past(clkrunLow) && !pinOut[6])
		else $error("pin 6 clock run drive wrong");
	a_gpo_pin_five: assert property (route[23:20] == mpr_pkg::FN_GPO |=>
		pinOe[5] && pinOut[5] == $past(gpo[4]))
		else $error("pin 5 does not carry general output 4");
	a_lock_no_drive: assert property (route[19:16] == mpr_pkg::FN_LOCK && !eepromMode |=>
		!pinOe[4])
		else $error("pin 4 driven while it is a lock input");
	a_input_no_drive: assert property (route[11:8] == mpr_pkg::FN_INPUT |=> !pinOe[2])
		else $error("pin 2 driven while it is an input");
	a_route_hold: assert property (registerHold [*4] ##0 !routeWrite |=> $stable(route))
		else $error("routing cleared while held");
endmodule

// ---- verif/multifunction_pin_router_tb.sv ----
`timescale 1ns/1ns
// Drives the router through its ports; expectations come from the per-pin function tables.
module multifunction_pin_router_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] pinDrv = 7'h55;
	logic [6:0] pinIn, pinOut, pinOe, parIrq = 7'h7F;
	logic eepromStrap = 1'b1, globalResetIn_n = 1'b1, busResetIn_n = 1'b1, registerHold = 1'b0;
	logic [1:0] cardSpeakerIn = 2'h0;
	logic routeWrite = 1'b0, gpoWrite = 1'b0, nackAddr = 1'b0, eeLow, sclLine, sdaLine;
	logic [27:0] routeWrData = 28'h000_0000, route;
	logic [4:0] gpoWrData = 5'h00, gpo, generalInput;
	logic intaReq = 1'b1, intbReq = 1'b1, ledActive = 1'b1, videoSwitch = 1'b1, audioPwm = 1'b1;
	logic gpeEvent = 1'b1, ringIndicate = 1'b1, powerEvent = 1'b0, ringPmeSelect = 1'b0;
	logic serirqOut = 1'b1, serirqOe = 1'b1, clkrunLow = 1'b1, dmaReq = 1'b1;
	logic ringPmeOut, hostSpeakerOut, eepromMode, eepromDone, eepromError, dmaGrant;
	logic [15:0] subsystemId, loadedDefaults;
	logic [15:0] legal [7] = '{16'h00FF, 16'h00FF, 16'h11FD, 16'h0281, 16'h09FD, 16'h20FD, 16'h0481};
	int fails = 0;
	int tests_run = 0;

	// Pins read back what drives them; the EEPROM sees the bus only in serial mode.
	assign pinIn = ((pinOe & pinOut) | (~pinOe & pinDrv)) & ~{5'h00, eeLow, 1'b0};
	assign sclLine = eepromMode ? pinIn[4] : 1'b1;
	assign sdaLine = eepromMode ? pinIn[1] : 1'b1;

	mpr_router mpr_router_inst (.clock, .rst_n, .pinIn, .pinOut, .pinOe, .eepromStrap,
		.globalResetIn_n, .busResetIn_n, .registerHold, .cardSpeakerIn, .routeWrite, .routeWrData,
		.gpoWrite, .gpoWrData, .intaReq, .intbReq, .ledActive, .videoSwitch, .audioPwm, .gpeEvent,
		.parIrq, .ringIndicate, .powerEvent, .ringPmeSelect, .serirqOut, .serirqOe, .clkrunLow,
		.dmaReq, .route, .gpo, .generalInput, .lockIn(), .dmaGrant, .clkrunIn(), .serirqIn(),
		.ringPmeOut, .hostSpeakerOut, .eepromMode, .eepromDone, .eepromError, .subsystemId,
		.loadedDefaults);

	mpr_eeprom_model mpr_eeprom_model_inst (.scl(sclLine), .sda(sdaLine), .nackAddr,
		.sdaLow(eeLow));

	initial begin
		forever #25 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (fails == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One write strobe, then the next edge to let the register update land.
	task automatic wr(input logic isGpo, input logic [27:0] d);
		@(posedge clock);
		routeWrData <= d;
		gpoWrData <= d[4:0];
		routeWrite <= !isGpo;
		gpoWrite <= isGpo;
		@(posedge clock);
		routeWrite <= 1'b0;
		gpoWrite <= 1'b0;
		@(negedge clock);
	endtask

	// Bus reset pulse; the strap level decides whether a load follows, bounded by a timeout.
	task automatic busReset(input logic strap, input logic forErr);
		@(posedge clock);
		eepromStrap <= strap;
		busResetIn_n <= 1'b0;
		repeat (4) @(posedge clock);
		busResetIn_n <= 1'b1;
		for (int n = 0; n < 30000; n++) begin
			@(negedge clock);
			if ((forErr ? eepromError : eepromDone) === 1'b1) begin
				return;
			end
		end
		fails++;
		print_verdict();
	endtask

	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		// The synchronised reset pins read low for two edges and would wipe an early write.
		repeat (2) @(posedge clock);
		wr(1'b1, 28'h000_001F);
		check(gpo, 5'h1F);
		check(generalInput, 5'h0D);
		// Every code on every pin at once; illegal codes must read back as zero and stay off.
		for (int c = 0; c < 14; c++) begin
			wr(1'b0, {7{c[3:0]}});
			@(negedge clock);
			for (int p = 0; p < 7; p++) begin
				check(route[4*p +: 4], legal[p][c] ? c[3:0] : 4'h0);
				check(pinOe[p], legal[p][c] && !(c == 0 || c == 11 || c == 13));
				check(pinOut[p], legal[p][c] && (c >= 2 && c <= 9 || c == 12));
			end
			check(dmaGrant, c != 13 || pinDrv[5]);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			cardSpeakerIn <= i[1:0];
			ringPmeSelect <= i[0];
			ringIndicate <= i[1];
			powerEvent <= !i[1];
			repeat (4) @(posedge clock);
			@(negedge clock);
			check(hostSpeakerOut, ^i[1:0]);
			check(ringPmeOut, i[0] ? !i[1] : i[1]);
		end
		wr(1'b0, 28'h765_4321);
		check(route, 28'h765_0321);
		// Both resets while held, then with the hold dropped.
		@(posedge clock);
		registerHold <= 1'b1;
		repeat (3) @(posedge clock);
		globalResetIn_n <= 1'b0;
		busResetIn_n <= 1'b0;
		repeat (6) @(posedge clock);
		@(negedge clock);
		check(route, 28'h765_0321);
		check(gpo, 5'h1F);
		@(posedge clock);
		registerHold <= 1'b0;
		repeat (6) @(posedge clock);
		@(negedge clock);
		check(route, 28'h000_0000);
		check(gpo, 5'h00);
		@(posedge clock);
		globalResetIn_n <= 1'b1;
		busResetIn_n <= 1'b1;
		pinDrv <= 7'h7F;
		busReset(1'b0, 1'b0);
		check(eepromMode, 1'b1);
		check(subsystemId, 16'hA53C);
		check(loadedDefaults, 16'hC35A);
		check(eepromError, 1'b0);
		@(posedge clock);
		nackAddr <= 1'b1;
		busReset(1'b0, 1'b1);
		check(eepromDone, 1'b0);
		check(subsystemId, 16'hA53C);
		print_verdict();
	end
endmodule

bind mpr_router mpr_router_asserts mpr_router_asserts_inst (.clock, .rst_n, .route, .pinOut,
	.pinOe, .gpo, .cardSpeakerIn, .hostSpeakerOut, .ringPmeSelect, .powerEvent, .ringIndicate,
	.ringPmeOut, .ledActive, .intaReq, .parIrq, .clkrunLow, .registerHold, .routeWrite,
	.eepromMode);
